/* src/pcs_pkg.sv */
// Package for the PLL switchover sequencer: constants, pin and status
// bundles, and the sequencer state type.
// Assumes a single 100 MHz system clock domain.
package pcs_pkg;

    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned RESET_MIN_NS     = 10;
    // Least reset width, rounded up to whole cycles, never below one
    localparam int unsigned RESET_MIN_CYCLES =
        ((RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
        ((RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Cycles the raw lock must stay high before lock is reported
    localparam int unsigned LOCK_STABLE_CYCLES = 8;

    // Counter widths
    localparam int unsigned STABLE_W = 4;
    localparam int unsigned RSTCNT_W = 4;

    // Values after reset
    localparam logic REF_SELECT_RESET = 1'b0;
    localparam logic [STABLE_W-1:0] STABLE_RESET = 4'h0;
    localparam logic [RSTCNT_W-1:0] RSTCNT_RESET = 4'h0;

    // Sized forms of the counts
    localparam logic [STABLE_W-1:0] STABLE_LAST =
        STABLE_W'(LOCK_STABLE_CYCLES - 1);
    localparam logic [RSTCNT_W-1:0] RSTCNT_MIN = RSTCNT_W'(RESET_MIN_CYCLES);
    localparam logic [RSTCNT_W-1:0] RSTCNT_MAX = 4'hf;

    // Pins arriving from outside the clock domain
    typedef struct packed {
        logic switchReq;
        logic pllReset;
        logic analogLock;
        logic primary_clock_fault;
        logic secondary_clock_fault;
        logic pfdEnable;
    } pcs_pins_t;

    // Synchroniser value after reset: pins at their idle levels
    localparam pcs_pins_t PINS_IDLE = '{pfdEnable: 1'b1, default: 1'b0};

    // Status bundle driven back out
    typedef struct packed {
        logic refSelect;
        logic switchActive;
        logic lockOut;
        logic phaseAligned;
        logic holdover;
        logic lockLost;
        logic switchFault;
    } pcs_status_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_RESYNC,
        ST_RESET
    } pcs_state_t;

endpackage

/* src/pcs_switchover.sv */
// Sequencer for manual reference clock switchover inside the PLL block.
// All pins arrive asynchronously and are synchronised on mclk.
`timescale 1ns/1ps
`default_nettype none

module pcs_switchover (
    // Clock, reset, enable
    input  wire logic             mclk,
    input  wire logic             arst_n,
    input  wire logic             ce,
    // Asynchronous pins
    input  wire pcs_pkg::pcs_pins_t pinsIn,
    // Same-domain flag clear
    input  wire logic             clearFlags,
    // Status
    output var  pcs_pkg::pcs_status_t status
);
    import pcs_pkg::*;

    typedef struct packed {
        pcs_pins_t                sync1;
        pcs_pins_t                sync2;
        logic                     reqPrev;
        pcs_state_t               fsm;
        logic                     refSel;
        logic [STABLE_W-1:0]      stableCnt;
        logic [RSTCNT_W-1:0]      rstCnt;
        logic                     realign;
        logic                     lockOut;
        logic                     phaseAligned;
        logic                     lockLost;
        logic                     switchFault;
        logic                     holdover;
        logic                     switchActive;
    } pcs_regs_t;

    localparam pcs_regs_t REGS_RESET = '{
        sync1:        PINS_IDLE, // No false holdover after reset
        sync2:        PINS_IDLE,
        reqPrev:      1'b0,
        fsm:          ST_RESYNC,
        refSel:       REF_SELECT_RESET,
        stableCnt:    STABLE_RESET,
        rstCnt:       RSTCNT_RESET,
        realign:      1'b0,
        lockOut:      1'b0,
        phaseAligned: 1'b0,
        lockLost:     1'b0,
        switchFault:  1'b0,
        holdover:     1'b0,
        switchActive: 1'b0
    };

    pcs_regs_t r;
    pcs_regs_t next_r;

    // Saturating increment of the reset width counter
    function automatic logic [RSTCNT_W-1:0] rstInc(
        input logic [RSTCNT_W-1:0] v
    );
        rstInc = (v == RSTCNT_MAX) ? v : RSTCNT_W'(v + 1'b1);
    endfunction

    // Next-state logic
    always_comb begin
        pcs_pins_t s;
        logic      reqRise;
        s       = r.sync2;
        reqRise = s.switchReq & ~r.reqPrev;
        next_r  = r;
        // Two-stage synchroniser; only stage two is read below
        next_r.sync1   = pinsIn;
        next_r.sync2   = r.sync1;
        next_r.reqPrev = s.switchReq;
        // Oscillator holds frequency while detector is off
        next_r.holdover = ~s.pfdEnable;
        // Clear first so a same-cycle event still sets the flag
        if (clearFlags) begin
            next_r.lockLost    = 1'b0;
            next_r.switchFault = 1'b0;
        end
        if (r.lockOut && !s.analogLock) begin
            next_r.lockLost = 1'b1;
        end
        case (r.fsm)
            ST_RUN: begin
                if (s.pllReset) begin
                    next_r.fsm          = ST_RESET;
                    next_r.rstCnt       = 4'h1;
                    next_r.lockOut      = 1'b0;
                    next_r.phaseAligned = 1'b0;
                end else if (reqRise) begin
                    // Swap references and wait for the loop to settle
                    next_r.fsm          = ST_RESYNC;
                    next_r.refSel       = ~r.refSel;
                    next_r.switchActive = 1'b1;
                    next_r.lockOut      = 1'b0;
                    next_r.phaseAligned = 1'b0;
                    next_r.realign      = 1'b0;
                    next_r.stableCnt    = STABLE_RESET;
                    if (s.primary_clock_fault || s.secondary_clock_fault) begin
                        next_r.switchFault = 1'b1;
                    end
                end else if (!s.analogLock) begin
                    // Lock dropped on its own; go back and resync
                    next_r.fsm       = ST_RESYNC;
                    next_r.lockOut   = 1'b0;
                    next_r.stableCnt = STABLE_RESET;
                end
            end
            ST_RESYNC: begin
                if (s.pllReset) begin
                    next_r.fsm          = ST_RESET;
                    next_r.rstCnt       = 4'h1;
                    next_r.phaseAligned = 1'b0;
                end else if (reqRise) begin
                    next_r.refSel       = ~r.refSel;
                    next_r.switchActive = 1'b1;
                    next_r.realign      = 1'b0;
                    next_r.stableCnt    = STABLE_RESET;
                    if (s.primary_clock_fault || s.secondary_clock_fault) begin
                        next_r.switchFault = 1'b1;
                    end
                end else if (s.analogLock) begin
                    // Resync time is open-ended; demand a stable run
                    if (r.stableCnt == STABLE_LAST) begin
                        next_r.fsm          = ST_RUN;
                        next_r.lockOut      = 1'b1;
                        next_r.switchActive = 1'b0;
                        next_r.phaseAligned = r.realign;
                    end else begin
                        next_r.stableCnt = STABLE_W'(r.stableCnt + 1'b1);
                    end
                end else begin
                    next_r.stableCnt = STABLE_RESET;
                end
            end
            ST_RESET: begin
                next_r.lockOut = 1'b0;
                if (s.pllReset) begin
                    // Width of the reset as seen on mclk
                    next_r.rstCnt = rstInc(r.rstCnt);
                end else begin
                    // Long enough reset realigns phase after relock
                    next_r.realign   = (r.rstCnt >= RSTCNT_MIN);
                    next_r.fsm       = ST_RESYNC;
                    next_r.stableCnt = STABLE_RESET;
                end
            end
            default: begin
                next_r = REGS_RESET;
            end
        endcase
    end

    // State register, frozen while ce is low
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            r <= REGS_RESET;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // Status straight from flip-flops
    always_comb begin
        status.refSelect    = r.refSel;
        status.switchActive = r.switchActive;
        status.lockOut      = r.lockOut;
        status.phaseAligned = r.phaseAligned;
        status.holdover     = r.holdover;
        status.lockLost     = r.lockLost;
        status.switchFault  = r.switchFault;
    end

endmodule

`default_nettype wire

/* tb/pcs_ctrl_model.sv */
// Controller model driving the sequencer pins.
// Assumes bench commands change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module pcs_ctrl_model (
    // Bench commands
    input  wire logic           mclk,
    input  wire logic           cmdSwitch,
    input  wire logic           cmdReset,
    input  wire logic           cmdHold,
    input  wire logic           badReq,
    input  wire logic           lockIn,
    input  wire logic [1:0]     faults,
    // Sequencer side
    input  wire pcs_pkg::pcs_status_t status,
    output var  pcs_pkg::pcs_pins_t   pins,
    output var  logic           outEn
);
    import pcs_pkg::*;
    int rstLeft = 0;
    // Reset width counted on mclk, never short
    always @(posedge mclk) begin
        rstLeft <= cmdReset ? RESET_MIN_CYCLES - 1 : (rstLeft > 0 ? rstLeft - 1 : 0);
    end
    // Pin levels
    always_comb begin
        pins.switchReq = cmdSwitch && (faults == 2'h0 || badReq);
        pins.pllReset = cmdReset || rstLeft > 0;
        pins.analogLock = lockIn;
        pins.primary_clock_fault = faults[0];
        pins.secondary_clock_fault = faults[1];
        pins.pfdEnable = !cmdHold;
        outEn = status.lockOut;
    end
endmodule
`default_nettype wire

/* tb/pcs_switchover_properties.sv */
// Timing checks on the sequencer ports.
// Assumes ce held high.
`timescale 1ns/1ps
`default_nettype none
module pcs_switchover_properties (
    input wire logic           mclk,
    input wire logic           arst_n,
    input wire logic           ce,
    input wire pcs_pkg::pcs_pins_t   pinsIn,
    input wire logic           clearFlags,
    input wire pcs_pkg::pcs_status_t status
);
    import pcs_pkg::*;
    logic [3:0] lockRun;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // Saturating run length of raw lock
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) lockRun <= 4'h0;
        else lockRun <= pinsIn.analogLock ? lockRun + {3'h0, lockRun != 4'hf} : 4'h0;
    end
    sequence req_s;
        $rose(pinsIn.switchReq) && !pinsIn.pllReset &&
            !pinsIn.primary_clock_fault && !pinsIn.secondary_clock_fault;
    endsequence
    a_reset_status_clear: assert property ($rose(arst_n) |-> status == '0) else $error("status not clear");
    a_req_toggles_ref: assert property (req_s |-> ##[2:4] $changed(status.refSelect)) else $error("no ref toggle");
    a_req_sets_active: assert property (req_s |-> ##[2:4] status.switchActive) else $error("no switch active");
    a_active_end_lock: assert property ($fell(status.switchActive) |-> status.lockOut) else $error("active ended unlocked");
    a_lock_stable_run: assert property ($rose(status.lockOut) |-> lockRun >= 4'h9) else $error("lock too early");
    a_lock_drop_flag: assert property (status.lockOut && !pinsIn.analogLock |-> ##[1:4] (!status.lockOut && status.lockLost)) else $error("lock loss missed");
    a_lost_sticky: assert property (status.lockLost && !clearFlags |=> status.lockLost) else $error("lost flag dropped");
    a_fault_req_flag: assert property ($rose(pinsIn.switchReq) && pinsIn.primary_clock_fault |-> ##[2:4] status.switchFault) else $error("fault missed");
    a_holdover_follow: assert property (!pinsIn.pfdEnable [*5] |-> status.holdover) else $error("no holdover");
    a_aligned_locked: assert property ($rose(status.phaseAligned) |-> status.lockOut) else $error("aligned unlocked");
    c_switch: cover property (req_s);
    c_aligned: cover property ($rose(status.phaseAligned));
    c_lost: cover property ($rose(status.lockLost));
endmodule
bind pcs_switchover pcs_switchover_properties chk (.mclk(mclk), .arst_n(arst_n),
    .ce(ce), .pinsIn(pinsIn), .clearFlags(clearFlags), .status(status));
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the switchover sequencer.
// Assumes the controller model drives the pins.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pcs_pkg::*;
    logic        mclk, arst_n, clearFlags, cmdSwitch, cmdReset, cmdHold;
    logic        badReq, lockIn, outEn;
    logic [1:0]  faults;
    pcs_pins_t   pins;
    pcs_status_t status;
    int          error_cnt = 0;
    int          checked = 0;
    pcs_switchover DUT (.mclk(mclk), .arst_n(arst_n), .ce(1'b1), .pinsIn(pins),
        .clearFlags(clearFlags), .status(status));
    pcs_ctrl_model ctrl (.mclk(mclk), .cmdSwitch(cmdSwitch), .cmdReset(cmdReset),
        .cmdHold(cmdHold), .badReq(badReq), .lockIn(lockIn), .faults(faults),
        .status(status), .pins(pins), .outEn(outEn));
    // Clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic seen, input logic exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t saw %b expected %b", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wait_lock();
        int i;
        for (i = 0; i < 40 && status.lockOut !== 1'b1; i++) cyc(1);
        if (status.lockOut !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t lock wait timed out", $time);
            complete_run();
        end
    endtask
    task automatic pulse_clear();
        clearFlags = 1'b1;
        cyc(1);
        clearFlags = 1'b0;
        cyc(1);
    endtask
    // Lock reported only after a stable run
    task automatic t_boot();
        lockIn = 1'b1;
        cyc(1);
        chk(status.holdover, 1'b0);
        cyc(7);
        chk(status.lockOut, 1'b0);
        wait_lock();
        chk(outEn, 1'b1);
    endtask
    // Switch, optionally followed by a realigning reset
    task automatic t_switch(input logic realign);
        logic sel;
        sel = status.refSelect;
        cmdSwitch = 1'b1;
        cyc(5);
        cmdSwitch = 1'b0;
        chk(status.refSelect, ~sel);
        chk(outEn, 1'b0);
        cmdReset = realign;
        cyc(1);
        cmdReset = 1'b0;
        wait_lock();
        chk(status.switchActive, 1'b0);
        chk(status.phaseAligned, realign);
    endtask
    // Lock loss flagged and cleared
    task automatic t_loss();
        lockIn = 1'b0;
        cyc(5);
        chk(status.lockOut, 1'b0);
        chk(status.lockLost, 1'b1);
        pulse_clear();
        chk(status.lockLost, 1'b0);
        lockIn = 1'b1;
        wait_lock();
    endtask
    // Request while a reference is faulty
    task automatic t_fault();
        faults = 2'h1;
        badReq = 1'b1;
        cmdSwitch = 1'b1;
        cyc(5);
        cmdSwitch = 1'b0;
        chk(status.switchFault, 1'b1);
        faults = 2'h0;
        badReq = 1'b0;
        pulse_clear();
        chk(status.switchFault, 1'b0);
        wait_lock();
    endtask
    // Phase detector off gives holdover
    task automatic t_hold();
        cmdHold = 1'b1;
        cyc(5);
        chk(status.holdover, 1'b1);
        cmdHold = 1'b0;
        cyc(5);
        chk(status.holdover, 1'b0);
    endtask
    // Main sequence
    initial begin
        {arst_n, clearFlags, cmdSwitch, cmdReset, cmdHold, badReq, lockIn} = '0;
        faults = 2'h0;
        cyc(5);
        arst_n = 1'b1;
        t_boot();
        t_switch(1'b0);
        t_switch(1'b1);
        t_loss();
        t_fault();
        t_hold();
        complete_run();
    end
endmodule
`default_nettype wire
